// [src/rmc_pkg.sv]
/*
 * Constants, timing figures and mode enumeration for the radio mode controller.
 * Assumes a 100 MHz core clock; carrier, settle and chip-enable times are converted to cycles here.
 */
`default_nettype none
package rmc_pkg;
    localparam int CLK_MHZ = 100;
    // Carrier must persist this long before the flag rises
    localparam int CD_MIN_US = 128;
    localparam int CD_CYCLES = CD_MIN_US * CLK_MHZ;
    // Settling time from standby to transmit or receive
    localparam int SETTLE_MAX_US = 130;
    localparam int SETTLE_CYCLES = SETTLE_MAX_US * CLK_MHZ;
    // Least chip-enable pulse that launches one packet
    localparam int CE_MIN_US = 10;
    localparam int CE_MIN_CYCLES = CE_MIN_US * CLK_MHZ;
    // On-air bit time in ns at each rate; link bits are 8 per byte
    localparam int BIT_NS_1M = 1000;
    localparam int BIT_NS_2M = 500;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int MAX_PAYLOAD = 32;
    localparam int PKT_OVERHEAD_BYTES = 9;
    localparam int FIFO_DEPTH = 8;
    localparam int DATA_W = 8;
    localparam logic [5:0] LEN_RESET = 6'h01;
    typedef enum logic [2:0] {
        RMC_POWER_DOWN,
        RMC_STANDBY_1,
        RMC_STANDBY_2,
        RMC_RX_SETTLE,
        RMC_RX,
        RMC_TX_SETTLE,
        RMC_TX
    } rmc_mode_e;
endpackage
`default_nettype wire

// [src/rmc_fifo.sv]
/*
 * Parameterised first-in first-out buffer with valid/ready on both sides.
 * Assumes one clock, asynchronous active-low reset and a shared clock enable.
 */
`default_nettype none
module rmc_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic full_o,
    output logic empty_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign full_o = (count == (AW+1)'(DEPTH));
    assign empty_o = (count == '0);
    assign in_ready_o = ce_i && !full_o;
    assign out_valid_o = !empty_o;
    assign push = in_valid_i && in_ready_o;
    assign pop = ce_i && out_ready_i && !empty_o;
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [src/rmc_top.sv]
/*
 * Operating-mode state machine of the packet radio with carrier filter,
 * receive packet acceptance and transmit packet timing.
 * Assumes the controller keeps its configuration in its own registers and
 * presents power-up, receive select and chip enable as levels; the link
 * clock and the radio detect signals arrive asynchronously.
 */
`default_nettype none
module rmc_top
    import rmc_pkg::*;
#(
    parameter int CD_CYC = CD_CYCLES,
    parameter int SETTLE_CYC = SETTLE_CYCLES,
    parameter int CE_MIN_CYC = CE_MIN_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic power_up_bit_i,
    input wire logic primary_receive_select_i,
    input wire logic chip_enable_i,
    input wire logic rate_2m_i,
    input wire logic [5:0] payload_len_i,
    input wire logic tx_load_i,
    input wire logic rf_detect_i,
    input wire logic link_clk_i,
    input wire logic rx_bit_i,
    input wire logic rx_pkt_end_i,
    input wire logic rx_addr_ok_i,
    input wire logic rx_crc_ok_i,
    output logic rx_ready_o,
    output logic [DATA_W-1:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_take_i,
    output logic rx_full_o,
    output logic rx_drop_o,
    output logic [2:0] mode_o,
    output logic carrier_detect_flag_o,
    output logic tx_busy_o,
    output logic tx_done_o,
    output logic tx_fifo_empty_o
);
    // ----------------------------------------------------------------
    // Synchronisers
    // ----------------------------------------------------------------
    logic [1:0] det_sync;
    logic [1:0] lclk_sync;
    logic [1:0] bit_sync;
    logic [1:0] end_sync;
    logic [1:0] ok_sync;
    logic lclk_prev;
    logic end_prev;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            det_sync <= 2'h0;
            lclk_sync <= 2'h0;
            bit_sync <= 2'h0;
            end_sync <= 2'h0;
            ok_sync <= 2'h0;
            lclk_prev <= 1'b0;
            end_prev <= 1'b0;
        end
        else if (ce_i)
        begin
            det_sync <= {det_sync[0], rf_detect_i};
            lclk_sync <= {lclk_sync[0], link_clk_i};
            bit_sync <= {bit_sync[0], rx_bit_i};
            end_sync <= {end_sync[0], rx_pkt_end_i};
            ok_sync <= {ok_sync[0], rx_addr_ok_i && rx_crc_ok_i};
            lclk_prev <= lclk_sync[1];
            end_prev <= end_sync[1];
        end
    end

    // ----------------------------------------------------------------
    // Mode machine
    // ----------------------------------------------------------------
    rmc_mode_e mode;
    rmc_mode_e next_mode;
    logic [31:0] settle_cnt;
    logic [31:0] ce_cnt;
    logic [31:0] tx_cnt;
    logic [31:0] tx_len_cyc;
    logic ce_pulse_ok;
    logic tx_empty;
    logic tx_end;
    logic settled;
    logic tx_more;

    assign settled = (settle_cnt == 32'(SETTLE_CYC - 1));
    assign tx_end = (mode == RMC_TX) && (tx_cnt == tx_len_cyc - 32'h1);

    // Packet air time from payload length and rate
    always_comb
    begin
        tx_len_cyc = 32'((32'(payload_len_i) + 32'(PKT_OVERHEAD_BYTES)) * 8 *
            (rate_2m_i ? BIT_NS_2M : BIT_NS_1M) / CLK_NS);
    end

    always_comb
    begin
        next_mode = mode;
        case (mode)
            RMC_POWER_DOWN:
            begin
                if (power_up_bit_i)
                begin
                    next_mode = RMC_STANDBY_1;
                end
            end
            RMC_STANDBY_1:
            begin
                if (chip_enable_i && primary_receive_select_i)
                begin
                    next_mode = RMC_RX_SETTLE;
                end
                else if (ce_pulse_ok && !primary_receive_select_i && !tx_empty)
                begin
                    next_mode = RMC_TX_SETTLE;
                end
                else if (chip_enable_i && !primary_receive_select_i && tx_empty && ce_pulse_ok)
                begin
                    next_mode = RMC_STANDBY_2;
                end
            end
            RMC_STANDBY_2:
            begin
                if (!chip_enable_i || primary_receive_select_i)
                begin
                    next_mode = RMC_STANDBY_1;
                end
                else if (!tx_empty)
                begin
                    next_mode = RMC_TX_SETTLE;
                end
            end
            RMC_RX_SETTLE:
            begin
                if (!chip_enable_i)
                begin
                    next_mode = RMC_STANDBY_1;
                end
                else if (settled)
                begin
                    next_mode = RMC_RX;
                end
            end
            RMC_RX:
            begin
                if (!chip_enable_i || !primary_receive_select_i)
                begin
                    next_mode = RMC_STANDBY_1;
                end
            end
            RMC_TX_SETTLE:
            begin
                if (settled)
                begin
                    next_mode = RMC_TX;
                end
            end
            RMC_TX:
            begin
                if (tx_end)
                begin
                    if (!chip_enable_i)
                    begin
                        next_mode = RMC_STANDBY_1;
                    end
                    else if (!tx_more)
                    begin
                        next_mode = RMC_STANDBY_2;
                    end
                end
            end
            default:
            begin
                next_mode = RMC_POWER_DOWN;
            end
        endcase
        if (!power_up_bit_i)
        begin
            next_mode = RMC_POWER_DOWN;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode <= RMC_POWER_DOWN;
        end
        else if (ce_i)
        begin
            mode <= next_mode;
        end
    end

    // Settling and chip-enable pulse counters
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            settle_cnt <= 32'h0;
            ce_cnt <= 32'h0;
            ce_pulse_ok <= 1'b0;
        end
        else if (ce_i)
        begin
            settle_cnt <= (next_mode == mode && (mode == RMC_RX_SETTLE || mode == RMC_TX_SETTLE))
                ? settle_cnt + 32'h1 : 32'h0;
            if (chip_enable_i)
            begin
                if (ce_cnt < 32'(CE_MIN_CYC))
                begin
                    ce_cnt <= ce_cnt + 32'h1;
                end
            end
            else
            begin
                ce_cnt <= 32'h0;
            end
            // Latched pulse survives chip enable falling; cleared once the mode leaves standby-I
            // Held chip enable keeps the latch set
            if (chip_enable_i && ce_cnt >= 32'(CE_MIN_CYC - 1))
            begin
                ce_pulse_ok <= 1'b1;
            end
            else if (mode != RMC_STANDBY_1 || !power_up_bit_i)
            begin
                ce_pulse_ok <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Transmit packet counter
    // ----------------------------------------------------------------
    logic [5:0] tx_pkts;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tx_cnt <= 32'h0;
            tx_pkts <= 6'h0;
        end
        else if (ce_i)
        begin
            tx_cnt <= (mode == RMC_TX && !tx_end) ? tx_cnt + 32'h1 : 32'h0;
            if (!power_up_bit_i)
            begin
                tx_pkts <= 6'h0;
            end
            else if (tx_load_i && !tx_end && tx_pkts != 6'h3F)
            begin
                tx_pkts <= tx_pkts + 6'h1;
            end
            else if (tx_end && !tx_load_i && tx_pkts != 6'h0)
            begin
                tx_pkts <= tx_pkts - 6'h1;
            end
        end
    end
    assign tx_empty = (tx_pkts == 6'h0);
    // Packets left once the current one ends
    assign tx_more = (tx_pkts > 6'h1) || tx_load_i;

    // ----------------------------------------------------------------
    // Carrier detect filter
    // ----------------------------------------------------------------
    logic [31:0] cd_cnt;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cd_cnt <= 32'h0;
            carrier_detect_flag_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (mode != RMC_RX || !det_sync[1])
            begin
                cd_cnt <= 32'h0;
                carrier_detect_flag_o <= 1'b0;
            end
            else if (cd_cnt < 32'(CD_CYC))
            begin
                cd_cnt <= cd_cnt + 32'h1;
            end
            else
            begin
                carrier_detect_flag_o <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive deserialiser and packet acceptance
    // ----------------------------------------------------------------
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic byte_strobe;
    logic rx_in_ready;
    logic rx_empty;
    logic pkt_end;

    assign pkt_end = end_sync[1] && !end_prev;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            shift <= 8'h00;
            bit_cnt <= 3'h0;
            byte_strobe <= 1'b0;
            rx_drop_o <= 1'b0;
        end
        else if (ce_i)
        begin
            byte_strobe <= 1'b0;
            rx_drop_o <= 1'b0;
            if (mode == RMC_RX && lclk_sync[1] && !lclk_prev)
            begin
                shift <= {shift[6:0], bit_sync[1]};
                bit_cnt <= bit_cnt + 3'h1;
                byte_strobe <= (bit_cnt == 3'h7) && !pkt_end;
            end
            if (pkt_end || mode != RMC_RX)
            begin
                bit_cnt <= 3'h0;
            end
            if (mode == RMC_RX && pkt_end && ok_sync[1] && !rx_in_ready)
            begin
                rx_drop_o <= 1'b1;
            end
        end
    end

    // Each payload byte is offered as it completes while the address and CRC qualifiers are both high
    rmc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .in_valid_i(byte_strobe && ok_sync[1]),
        .in_ready_o(rx_in_ready),
        .in_data_i(shift),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_take_i),
        .out_data_o(rx_data_o),
        .full_o(rx_full_o),
        .empty_o(rx_empty)
    );

    assign rx_ready_o = rx_in_ready;
    assign mode_o = mode;
    assign tx_busy_o = (mode == RMC_TX);
    assign tx_done_o = tx_end;
    assign tx_fifo_empty_o = tx_empty;
endmodule
`default_nettype wire

// [verification/rmc_assertions.sv]
/*
 * Concurrent checks on the mode controller ports, bound into rmc_top.
 * Assumes the bound instance shares the carrier and settle parameters.
 */
`default_nettype none
module rmc_checker
    import rmc_pkg::*;
#(
    parameter int CD_CYC = CD_CYCLES,
    parameter int SETTLE_CYC = SETTLE_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic power_up_bit_i,
    input wire logic primary_receive_select_i,
    input wire logic chip_enable_i,
    input wire logic rf_detect_i,
    input wire logic rx_full_o,
    input wire logic rx_drop_o,
    input wire logic [2:0] mode_o,
    input wire logic carrier_detect_flag_o,
    input wire logic tx_busy_o,
    input wire logic tx_done_o,
    input wire logic tx_fifo_empty_o
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SETTLE_LIM = SETTLE_CYC + 2;
    int det_cnt;
    int settle_run;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // Raw detect run length
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            det_cnt <= 0;
        else if (!rf_detect_i)
            det_cnt <= 0;
        else if (det_cnt < CD_CYC)
            det_cnt <= det_cnt + 1;
    end

    // Settle state run length
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            settle_run <= 0;
        end
        else if (ce_i)
        begin
            settle_run <= (mode_o == 3'h3 || mode_o == 3'h5) ? settle_run + 1 : 0;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    pd_force_a: assert property (ce_i && !power_up_bit_i |=> mode_o == 3'h0)
        else $error("power down not entered");
    pd_wake_a: assert property (ce_i && mode_o == 3'h0 && power_up_bit_i |=> mode_o == 3'h1)
        else $error("standby-I not entered");
    rx_entry_a: assert property ($rose(mode_o == 3'h4) |->
        $past(power_up_bit_i & primary_receive_select_i & chip_enable_i))
        else $error("receive entered without enables");
    rx_leave_a: assert property (ce_i && power_up_bit_i && !chip_enable_i && mode_o == 3'h4
        |=> mode_o == 3'h1)
        else $error("receive kept with chip enable low");
    cd_idle_a: assert property (mode_o != 3'h4 && $past(mode_o) != 3'h4 |-> !carrier_detect_flag_o)
        else $error("carrier flag outside receive");
    cd_filter_a: assert property ($rose(carrier_detect_flag_o) |-> $past(det_cnt, 3) >= CD_CYC - 4)
        else $error("carrier flag too early");
    tx_entry_a: assert property ($rose(mode_o == 3'h5) |->
        $past(power_up_bit_i & !primary_receive_select_i & !tx_fifo_empty_o))
        else $error("transmit settle without payload");
    tx_hold_a: assert property (ce_i && power_up_bit_i && tx_busy_o && !tx_done_o |=> mode_o == 3'h6)
        else $error("transmit left early");
    tx_end_a: assert property (ce_i && power_up_bit_i && tx_done_o && !chip_enable_i
        |=> mode_o == 3'h1)
        else $error("no standby-I after packet");
    sb2_entry_a: assert property ($rose(mode_o == 3'h2) |->
        $past(chip_enable_i & !primary_receive_select_i))
        else $error("standby-II without chip enable");
    settle_max_a: assert property (settle_run <= SETTLE_LIM)
        else $error("settle too long");
    drop_full_a: assert property (rx_drop_o |-> $past(rx_full_o))
        else $error("drop with room in buffer");

    cover property (carrier_detect_flag_o && mode_o == 3'h4);
    cover property (tx_done_o && chip_enable_i);
    cover property (rx_drop_o);
endmodule

bind rmc_top rmc_checker #(.CD_CYC(CD_CYC), .SETTLE_CYC(SETTLE_CYC)) rmc_checker_inst (.clk_i, .rst_n_i,
    .ce_i, .power_up_bit_i, .primary_receive_select_i, .chip_enable_i, .rf_detect_i, .rx_full_o,
    .rx_drop_o, .mode_o, .carrier_detect_flag_o, .tx_busy_o, .tx_done_o, .tx_fifo_empty_o);
`default_nettype wire

// [verification/rmc_link_model.sv]
/*
 * Far-end link source: bit clock, serial data and packet qualifiers.
 * Assumes the bench calls send_frame; the bit clock idles low between frames.
 */
`default_nettype none
module rmc_link_model
(
    output logic link_clk_o,
    output logic bit_o,
    output logic pkt_end_o,
    output logic addr_ok_o,
    output logic crc_ok_o
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam realtime HALF = 62.5;

    initial
    begin
        link_clk_o = 1'b0;
        bit_o = 1'b0;
        pkt_end_o = 1'b0;
        addr_ok_o = 1'b0;
        crc_ok_o = 1'b0;
    end

    // ------------------------------------------------------------
    // One frame, bytes sent most significant bit first
    // ------------------------------------------------------------
    task automatic send_frame(input logic [7:0] b [$], input logic good);
        addr_ok_o = good;
        crc_ok_o = good;
        foreach (b[k])
            for (int i = 7; i >= 0; i--)
            begin
                bit_o = b[k][i];
                #HALF link_clk_o = 1'b1;
                #HALF link_clk_o = 1'b0;
            end
        #200 pkt_end_o = 1'b1;
        #200 pkt_end_o = 1'b0;
        addr_ok_o = 1'b0;
        crc_ok_o = 1'b0;
        // Released line shows the inverse level
        bit_o = ~bit_o;
    endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
/*
 * Self-checking bench for the radio mode controller.
 * Assumes shortened carrier, settle and chip-enable parameters.
 */
`default_nettype none
module testbench
    import rmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CD_T = 20;
    localparam int ST_T = 10;
    localparam int CE_T = 5;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic pwr = 1'b0, rxs = 1'b0, chen = 1'b0, r2m = 1'b0, tload = 1'b0, rfd = 1'b0, take = 1'b0;
    logic [5:0] plen = 6'h01;
    logic lclk, lbit, lend, laok, lcok, rdy, rval, rfull, rdrop, cdf, tbusy, tdone, tempty;
    logic [7:0] rdata;
    logic [2:0] mode;
    logic drop_seen = 1'b0;
    logic [7:0] q [$];
    int fail_count = 0;
    int n_tests = 0;
    int cnt;

    rmc_top #(.CD_CYC(CD_T), .SETTLE_CYC(ST_T), .CE_MIN_CYC(CE_T)) rmc_top_inst (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .ce_i(ce_i), .power_up_bit_i(pwr), .primary_receive_select_i(rxs),
        .chip_enable_i(chen), .rate_2m_i(r2m), .payload_len_i(plen), .tx_load_i(tload), .rf_detect_i(rfd),
        .link_clk_i(lclk), .rx_bit_i(lbit), .rx_pkt_end_i(lend), .rx_addr_ok_i(laok), .rx_crc_ok_i(lcok),
        .rx_ready_o(rdy), .rx_data_o(rdata), .rx_valid_o(rval), .rx_take_i(take), .rx_full_o(rfull),
        .rx_drop_o(rdrop), .mode_o(mode), .carrier_detect_flag_o(cdf), .tx_busy_o(tbusy), .tx_done_o(tdone),
        .tx_fifo_empty_o(tempty));
    rmc_link_model rmc_link_model_inst (.link_clk_o(lclk), .bit_o(lbit), .pkt_end_o(lend), .addr_ok_o(laok),
        .crc_ok_o(lcok));

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i)
        if (rdrop === 1'b1)
            drop_seen <= 1'b1;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] tx_cyc(input logic [5:0] len, input logic r2);
        return 16'((int'(len) + PKT_OVERHEAD_BYTES) * 8 * (r2 ? BIT_NS_2M : BIT_NS_1M) / CLK_NS);
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
            fail_count++;
        end
    endtask

    task automatic ticks(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic wait_mode(input logic [2:0] m, input int lim);
        int i;
        i = 0;
        while (mode !== m && i < lim)
        begin
            ticks(1);
            i++;
        end
    endtask

    task automatic wait_done();
        int i;
        i = 0;
        while (tdone !== 1'b1 && i < 20000)
        begin
            ticks(1);
            i++;
        end
        ticks(1);
    endtask

    task automatic load_pkt();
        tload = 1'b1;
        ticks(1);
        tload = 1'b0;
        ticks(1);
    endtask

    task automatic rx_pkt(input int n, input logic good, input int keep);
        logic [7:0] b [$];
        logic [7:0] v;
        for (int k = 0; k < n; k++)
        begin
            v = 8'($urandom);
            b.push_back(v);
            if (k < keep)
                q.push_back(v);
        end
        rmc_link_model_inst.send_frame(b, good);
        ticks(8);
    endtask

    task automatic drain(input int n);
        for (int k = 0; k < n; k++)
        begin
            chk("rx_valid", 16'h0001, 16'(rval));
            chk("rx_data", 16'(q.pop_front()), 16'(rdata));
            take = 1'b1;
            ticks(1);
            take = 1'b0;
            ticks(1);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        cnt = $urandom(32);
        ticks(4);
        rst_n_i = 1'b1;
        chk("mode", 16'h0000, 16'(mode));
        pwr = 1'b1;
        ticks(2);
        chk("mode", 16'h0001, 16'(mode));
        rxs = 1'b1;
        chen = 1'b1;
        ticks(2);
        chk("mode", 16'h0003, 16'(mode));
        wait_mode(3'h4, ST_T + 10);
        chk("mode", 16'h0004, 16'(mode));
        rfd = 1'b1;
        ticks(CD_T / 2);
        rfd = 1'b0;
        ticks(CD_T);
        chk("cd_flag", 16'h0000, 16'(cdf));
        rfd = 1'b1;
        ticks(CD_T + 12);
        chk("cd_flag", 16'h0001, 16'(cdf));
        rfd = 1'b0;
        ticks(5);
        chk("cd_flag", 16'h0000, 16'(cdf));
        rx_pkt(3, 1'b1, 3);
        drain(3);
        rx_pkt(2, 1'b0, 0);
        chk("rx_valid", 16'h0000, 16'(rval));
        rx_pkt(FIFO_DEPTH + 2, 1'b1, FIFO_DEPTH);
        chk("rx_full", 16'h0001, 16'(rfull));
        chk("rx_ready", 16'h0000, 16'(rdy));
        chk("rx_drop", 16'h0001, 16'(drop_seen));
        drain(FIFO_DEPTH);
        chk("rx_valid", 16'h0000, 16'(rval));
        chk("mode", 16'h0004, 16'(mode));
        // Clock enable low freezes the mode
        ce_i = 1'b0;
        chen = 1'b0;
        ticks(3);
        chk("mode", 16'h0004, 16'(mode));
        ce_i = 1'b1;
        ticks(2);
        chk("mode", 16'h0001, 16'(mode));
        chen = 1'b1;
        wait_mode(3'h4, ST_T + 10);
        pwr = 1'b0;
        ticks(2);
        chk("mode", 16'h0000, 16'(mode));
        pwr = 1'b1;
        rxs = 1'b0;
        ticks(2);
        chk("mode", 16'h0002, 16'(mode));
        chen = 1'b0;
        ticks(ST_T + 5);
        chk("mode", 16'h0001, 16'(mode));
        chk("tx_busy", 16'h0000, 16'(tbusy));
        // Short payloads keep each burst well inside the transmit limit
        plen = 6'($urandom_range(4, 1));
        r2m = 1'($urandom);
        load_pkt();
        chk("tx_empty", 16'h0000, 16'(tempty));
        chen = 1'b1;
        ticks(CE_T + 2);
        chen = 1'b0;
        wait_mode(3'h6, ST_T + 10);
        chk("mode", 16'h0006, 16'(mode));
        cnt = 0;
        while (tbusy === 1'b1 && cnt < 20000)
        begin
            ticks(1);
            cnt++;
        end
        chk("tx_len", tx_cyc(plen, r2m), 16'(cnt));
        chk("mode", 16'h0001, 16'(mode));
        r2m = ~r2m;
        chen = 1'b1;
        load_pkt();
        load_pkt();
        wait_mode(3'h6, ST_T + 20);
        wait_done();
        chk("mode", 16'h0006, 16'(mode));
        wait_done();
        chk("mode", 16'h0002, 16'(mode));
        load_pkt();
        chk("mode", 16'h0005, 16'(mode));
        chen = 1'b0;
        wait_mode(3'h6, ST_T + 10);
        wait_done();
        chk("mode", 16'h0001, 16'(mode));
        complete_run();
    end

    initial
    begin
        #1000000;
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
